// file: hw/rail_voltage_select_regs.sv
// Function
// - selected serial port alone reaches registers
// - gain field scales rail two target
// - codes 3..75 give code plus 45 steps
// - codes 75 and above clamp at 1.5 V
// - code zero off, 1..3 give 0.6 V
// - state field odd on; reset from nonvolatile
// - command bit picks converter scaled code
// - codes 3..67 give 48 over 45+code
// - codes 67 and above give 3/7
// - codes 1..3 give unity ratio
// - converter code zero drives enable low
// - command bit picks rail scaled code
`timescale 1ns/100ps
module rail_voltage_select_regs
    import rail_select_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       turnoff_event,
    input  wire logic       port_select_bit,
    input  wire logic [1:0] nv_state_default,
    input  wire gain_type   gain_select,
    input  wire logic [7:0] core_rail_two_operating_code,
    input  wire logic [7:0] external_converter_scaled_code,
    input  wire logic       ctl_wr,
    input  wire logic       ctl_rd,
    input  wire logic [7:0] ctl_addr,
    input  wire logic [7:0] ctl_wdata,
    output logic      [7:0] ctl_rdata,
    input  wire logic       scl_wr,
    input  wire logic       scl_rd,
    input  wire logic [7:0] scl_addr,
    input  wire logic [7:0] scl_wdata,
    output logic      [7:0] scl_rdata,
    output logic      [6:0] rail_two_applied_code,
    output logic      [9:0] rail_two_target,
    output logic            rail_two_enable,
    output logic      [6:0] ext_applied_code,
    output logic      [7:0] ext_divider_denominator,
    output logic            ext_converter_enable
);

    // ----------------------------------------
    // port selection
    // ----------------------------------------
    logic       acc_wr;
    logic       acc_rd;
    logic [7:0] acc_addr;
    logic [7:0] acc_wdata;
    logic [7:0] read_value;

    always_comb
    begin
        acc_wr    = port_select_bit ? scl_wr    : ctl_wr;
        acc_rd    = port_select_bit ? scl_rd    : ctl_rd;
        acc_addr  = port_select_bit ? scl_addr  : ctl_addr;
        acc_wdata = port_select_bit ? scl_wdata : ctl_wdata;
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic [6:0] scaled_sel;
    logic [1:0] ext_state;
    logic [7:0] ext_op;
    logic       init_pending;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            init_pending <= 1'b1;
        else
            init_pending <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            scaled_sel <= SCALED_CODE_RESET;
        else if (turnoff_event)
            scaled_sel <= SCALED_CODE_RESET;
        else if (acc_wr && acc_addr == SCALED_CODE_OFFSET)
            scaled_sel <= acc_wdata[SEL_MSB:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ext_state <= EXT_STATE_RESET;
        else if (turnoff_event || init_pending)
            ext_state <= nv_state_default;
        else if (acc_wr && acc_addr == EXT_STATE_OFFSET)
            ext_state <= acc_wdata[STATE_MSB:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ext_op <= EXT_OP_RESET;
        else if (turnoff_event)
            ext_op <= EXT_OP_RESET;
        else if (acc_wr && acc_addr == EXT_OP_OFFSET)
            ext_op <= acc_wdata;
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    always_comb
    begin
        if (acc_addr == SCALED_CODE_OFFSET)
            read_value = {1'b0, scaled_sel};
        else if (acc_addr == EXT_STATE_OFFSET)
            read_value = {6'h00, ext_state};
        else if (acc_addr == EXT_OP_OFFSET)
            read_value = ext_op;
        else
            read_value = 8'h00;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_rdata <= 8'h00;
        else if (ctl_rd)
            ctl_rdata <= port_select_bit ? 8'h00 : read_value;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            scl_rdata <= 8'h00;
        else if (scl_rd)
            scl_rdata <= port_select_bit ? read_value : 8'h00;
    end

    // ----------------------------------------
    // applied codes and decode
    // ----------------------------------------
    logic [6:0] rail_code;
    logic [6:0] ext_code;
    logic [9:0] next_rail_target;
    logic [7:0] next_denominator;
    logic       next_code_enable;
    logic       ext_on;

    always_comb
    begin
        rail_code = core_rail_two_operating_code[CMD_BIT]
                  ? scaled_sel
                  : core_rail_two_operating_code[SEL_MSB:0];
        ext_code  = ext_op[CMD_BIT]
                  ? external_converter_scaled_code[SEL_MSB:0]
                  : ext_op[SEL_MSB:0];
        ext_on    = ext_state[STATE_ON_BIT];
    end

    rail_target_decode rail_dec (
        .code   (rail_code),
        .gain   (gain_select),
        .target (next_rail_target)
    );

    divider_ratio_decode ext_dec (
        .code        (ext_code),
        .denominator (next_denominator),
        .enable      (next_code_enable)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail_two_applied_code <= 7'h00;
            rail_two_target       <= 10'h000;
            rail_two_enable       <= 1'b0;
        end
        else
        begin
            rail_two_applied_code <= rail_code;
            rail_two_target       <= next_rail_target;
            rail_two_enable       <= (rail_code != CODE_OFF);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_applied_code        <= 7'h00;
            ext_divider_denominator <= 8'h00;
            ext_converter_enable    <= 1'b0;
        end
        else
        begin
            ext_applied_code        <= ext_code;
            ext_divider_denominator <= next_denominator;
            ext_converter_enable    <= next_code_enable && ext_on;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_port_gating_write: assert property (
        ((port_select_bit ? ctl_wr : scl_wr) && !acc_wr && !turnoff_event)
        |=> $stable(scaled_sel) && $stable(ext_op))
        else $error("unselected port changed a register");

    chk_write_lands: assert property (
        (acc_wr && acc_addr == SCALED_CODE_OFFSET && !turnoff_event)
        |=> scaled_sel == $past(acc_wdata[6:0]))
        else $error("selected port write lost");

    chk_gain_triple: assert property (
        (gain_select == GAIN_X3 && rail_code >= RAIL_CODE_TOP)
        |=> rail_two_target == 10'h168)
        else $error("triple gain clamp wrong");

    chk_rail_linear: assert property (
        (gain_select == GAIN_X1 && rail_code inside {[7'h03:7'h4b]})
        |=> rail_two_target == {3'b000, $past(rail_code)} + 10'h02d)
        else $error("linear rail target wrong");

    chk_rail_clamp: assert property (
        (gain_select == GAIN_X1 && rail_code >= RAIL_CODE_TOP)
        |=> rail_two_target == 10'h078)
        else $error("rail clamp wrong");

    chk_rail_off_min: assert property (
        (rail_code == CODE_OFF) |=> rail_two_target == 10'h000 && !rail_two_enable)
        else $error("rail off code not off");

    chk_rail_min: assert property (
        (gain_select == GAIN_X1 && rail_code inside {[7'h01:7'h03]})
        |=> rail_two_target == 10'h030 && rail_two_enable)
        else $error("rail minimum wrong");

    chk_state_decode: assert property (
        (ext_code != CODE_OFF) |=> ext_converter_enable == $past(ext_state[0]))
        else $error("converter state decode wrong");

    chk_ext_select: assert property (
        ext_op[7] |=> ext_applied_code == $past(external_converter_scaled_code[6:0]))
        else $error("converter scaled code not applied");

    chk_div_linear: assert property (
        (ext_code inside {[7'h03:7'h43]})
        |=> ext_divider_denominator == {1'b0, $past(ext_code)} + 8'h2d)
        else $error("divider ratio wrong");

    chk_div_floor: assert property (
        (ext_code >= EXT_CODE_TOP) |=> ext_divider_denominator == 8'h70)
        else $error("divider floor wrong");

    chk_div_unity: assert property (
        (ext_code inside {[7'h01:7'h03]}) |=> ext_divider_denominator == 8'h30)
        else $error("unity ratio wrong");

    chk_ext_off: assert property (
        (ext_code == CODE_OFF) |=> !ext_converter_enable ##1 1'b1)
        else $error("converter enable not low");

    chk_rail_select: assert property (
        !core_rail_two_operating_code[7]
        |=> rail_two_applied_code == $past(core_rail_two_operating_code[6:0]))
        else $error("rail operating code not applied");

    chk_turnoff_restore: assert property (
        turnoff_event |=> scaled_sel == 7'h00 && ext_op == 8'h00
        && ext_state == $past(nv_state_default))
        else $error("turn-off reset not restored");

    chk_turnoff_beats_write: assert property (
        (turnoff_event && acc_wr && acc_addr == EXT_OP_OFFSET)
        |=> ext_op == EXT_OP_RESET)
        else $error("write won over turn-off reset");

    chk_reserved_read: assert property (
        (ctl_rd && !port_select_bit && ctl_addr == SCALED_CODE_OFFSET)
        |=> !ctl_rdata[7])
        else $error("reserved bit read not zero");

    cov_scaled_port: cover property (port_select_bit && scl_wr);
    cov_rail_scaled: cover property (core_rail_two_operating_code[7] && scaled_sel != 7'h00);
    cov_ext_on: cover property (ext_converter_enable ##1 !ext_converter_enable);
    cov_turnoff_write: cover property (turnoff_event && acc_wr);
    cov_gain_triple: cover property (gain_select == GAIN_X3 && rail_two_enable);

endmodule : rail_voltage_select_regs

// file: hw/rail_select_pkg.sv
package rail_select_pkg;

    // ----------------------------------------
    // register offsets and reset values
    // ----------------------------------------
    localparam logic [7:0] SCALED_CODE_OFFSET = 8'h26;
    localparam logic [7:0] EXT_STATE_OFFSET   = 8'h27;
    localparam logic [7:0] EXT_OP_OFFSET      = 8'h28;
    localparam logic [6:0] SCALED_CODE_RESET  = 7'h00;
    localparam logic [1:0] EXT_STATE_RESET    = 2'h0;
    localparam logic [7:0] EXT_OP_RESET       = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CMD_BIT      = 7;
    localparam int SEL_MSB      = 6;
    localparam int STATE_MSB    = 1;
    localparam int STATE_ON_BIT = 0;

    // ----------------------------------------
    // code decode points, in 12.5 mV steps
    // ----------------------------------------
    localparam int            STEP_UV        = 12500;
    localparam logic [6:0]    CODE_OFF       = 7'h00;
    localparam logic [6:0]    CODE_LOW_TOP   = 7'h03;
    localparam logic [6:0]    RAIL_CODE_TOP  = 7'h4b;
    localparam logic [6:0]    EXT_CODE_TOP   = 7'h43;
    localparam logic [7:0]    STEP_BIAS      = 8'h2d;
    localparam logic [7:0]    RAIL_MIN_STEPS = 8'h30;
    localparam logic [7:0]    RAIL_MAX_STEPS = 8'h78;

    // ----------------------------------------
    // divider ratio is numerator / denominator
    // ----------------------------------------
    localparam logic [7:0] DIV_NUMERATOR = 8'h30;
    localparam logic [7:0] DIV_UNITY_DEN = 8'h30;
    localparam logic [7:0] DIV_FLOOR_DEN = 8'h70;

    typedef enum logic [1:0] {
        GAIN_X1  = 2'h0,
        GAIN_ALT = 2'h1,
        GAIN_X2  = 2'h2,
        GAIN_X3  = 2'h3
    } gain_type;

endpackage : rail_select_pkg

// file: hw/rail_target_decode.sv
`timescale 1ns/100ps
module rail_target_decode
    import rail_select_pkg::*;
(
    input  wire logic [6:0] code,
    input  wire gain_type   gain,
    output logic      [9:0] target
);

    logic [7:0] base;

    // ----------------------------------------
    // unity-gain steps from the code
    // ----------------------------------------
    always_comb
    begin
        if (code == CODE_OFF)
            base = 8'h00;
        else if (code <= CODE_LOW_TOP)
            base = RAIL_MIN_STEPS;
        else if (code >= RAIL_CODE_TOP)
            base = RAIL_MAX_STEPS;
        else
            base = {1'b0, code} + STEP_BIAS;
    end

    // ----------------------------------------
    // gain scaling
    // ----------------------------------------
    always_comb
    begin
        case (gain)
            GAIN_X2: target = {1'b0, base, 1'b0};
            GAIN_X3: target = {2'b00, base} + {1'b0, base, 1'b0};
            default: target = {2'b00, base};
        endcase
    end

endmodule : rail_target_decode

// file: hw/divider_ratio_decode.sv
`timescale 1ns/100ps
module divider_ratio_decode
    import rail_select_pkg::*;
(
    input  wire logic [6:0] code,
    output logic      [7:0] denominator,
    output logic            enable
);

    // ----------------------------------------
    // ratio is numerator over denominator
    // ----------------------------------------
    always_comb
    begin
        enable = 1'b1;
        if (code == CODE_OFF)
        begin
            denominator = 8'h00;
            enable      = 1'b0;
        end
        else if (code <= CODE_LOW_TOP)
            denominator = DIV_UNITY_DEN;
        else if (code >= EXT_CODE_TOP)
            denominator = DIV_FLOOR_DEN;
        else
            denominator = {1'b0, code} + STEP_BIAS;
    end

endmodule : divider_ratio_decode

// file: dv/host_port_model.sv
`timescale 1ns/100ps
module host_port_model
(
    input  wire logic       clk,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial
    begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // ----------------------------------------
    // one access, then one idle cycle
    // ----------------------------------------
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
        @(posedge clk);
        #1;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd = 1'b0;
        addr = ~a;
        d = rdata;
        @(posedge clk);
        #1;
    endtask : read_reg
endmodule : host_port_model

// file: dv/tb_rail_voltage_select_regs.sv
`timescale 1ns/100ps
module tb_rail_voltage_select_regs
    import rail_select_pkg::*;
;
    logic       clk;
    logic       rst_n;
    logic       turnoff_event;
    logic       port_select_bit;
    logic [1:0] nv_state_default;
    logic [1:0] gain;
    logic [7:0] op_code;
    logic [7:0] ext_scaled;
    logic       ctl_wr, ctl_rd, scl_wr, scl_rd;
    logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, scl_addr, scl_wdata, scl_rdata;
    logic [6:0] rail_code, ext_code;
    logic [9:0] rail_target;
    logic       rail_en, ext_en;
    logic [7:0] ext_den;
    int         err_count = 0;
    int         checks = 0;
    int         cycles = 0;

    rail_voltage_select_regs rail_voltage_select_regs_i (
        .clk(clk), .rst_n(rst_n), .turnoff_event(turnoff_event),
        .port_select_bit(port_select_bit), .nv_state_default(nv_state_default),
        .gain_select(gain_type'(gain)), .core_rail_two_operating_code(op_code),
        .external_converter_scaled_code(ext_scaled),
        .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_addr(ctl_addr),
        .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
        .scl_wr(scl_wr), .scl_rd(scl_rd), .scl_addr(scl_addr),
        .scl_wdata(scl_wdata), .scl_rdata(scl_rdata),
        .rail_two_applied_code(rail_code), .rail_two_target(rail_target),
        .rail_two_enable(rail_en), .ext_applied_code(ext_code),
        .ext_divider_denominator(ext_den), .ext_converter_enable(ext_en));

    host_port_model ctl_host (.clk(clk), .wr(ctl_wr), .rd(ctl_rd), .addr(ctl_addr),
        .wdata(ctl_wdata), .rdata(ctl_rdata));
    host_port_model scl_host (.clk(clk), .wr(scl_wr), .rd(scl_rd), .addr(scl_addr),
        .wdata(scl_wdata), .rdata(scl_rdata));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic compare(input logic [9:0] got, input logic [9:0] exp, input string what);
        checks = checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : compare

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic p, input logic [7:0] a, input logic [7:0] d);
        if (p)
            scl_host.write_reg(a, d);
        else
            ctl_host.write_reg(a, d);
    endtask : wr_reg

    task automatic rd_check(input logic p, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        if (p)
            scl_host.read_reg(a, d);
        else
            ctl_host.read_reg(a, d);
        compare({2'h0, d}, {2'h0, e}, "read data");
    endtask : rd_check

    function automatic logic [9:0] exp_target(input logic [6:0] c, input logic [1:0] g);
        logic [9:0] s;
        s = (c == 7'h00) ? 10'h000 : (c <= 7'h03) ? 10'h030 :
            (c >= 7'h4b) ? 10'h078 : {3'h0, c} + 10'h02d;
        return s * ((g == 2'h3) ? 10'h003 : (g == 2'h2) ? 10'h002 : 10'h001);
    endfunction : exp_target

    function automatic logic [7:0] exp_den(input logic [6:0] c);
        return (c == 7'h00) ? 8'h00 : (c <= 7'h03) ? 8'h30 :
               (c >= 7'h43) ? 8'h70 : {1'b0, c} + 8'h2d;
    endfunction : exp_den

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset_values;
        rd_check(1'b0, 8'h26, 8'h00);
        rd_check(1'b0, 8'h27, 8'h02);
        rd_check(1'b0, 8'h28, 8'h00);
        rd_check(1'b0, 8'h2a, 8'h00);
        $display("test reset values done");
    endtask : test_reset_values

    task automatic test_port_select;
        wr_reg(1'b0, 8'h26, 8'hff);
        wr_reg(1'b1, 8'h26, 8'h11);
        rd_check(1'b1, 8'h26, 8'h00);
        rd_check(1'b0, 8'h26, 8'h7f);
        port_select_bit = 1'b1;
        wr_reg(1'b1, 8'h27, 8'hff);
        wr_reg(1'b0, 8'h27, 8'h00);
        rd_check(1'b1, 8'h27, 8'h03);
        rd_check(1'b0, 8'h27, 8'h00);
        port_select_bit = 1'b0;
        tick();
        $display("test port select done");
    endtask : test_port_select

    task automatic test_rail_decode;
        logic [6:0] codes [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
                                   7'h32, 7'h4a, 7'h4b, 7'h4c, 7'h7f};
        op_code = 8'h80;
        for (int g = 0; g < 4; g++)
        begin
            gain = g[1:0];
            for (int i = 0; i < 10; i++)
            begin
                wr_reg(1'b0, 8'h26, {1'b0, codes[i]});
                compare(rail_target, exp_target(codes[i], gain), "target");
                compare({9'h0, rail_en}, {9'h0, codes[i] != 7'h00}, "rail enable");
                compare({3'h0, rail_code}, {3'h0, codes[i]}, "rail code");
            end
        end
        op_code = 8'h10;
        tick();
        compare({3'h0, rail_code}, 10'h010, "rail op code");
        compare(rail_target, exp_target(7'h10, gain), "op target");
        gain = 2'h0;
        $display("test rail decode done");
    endtask : test_rail_decode

    task automatic test_ext_decode;
        logic [6:0] codes [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
                                   7'h23, 7'h42, 7'h43, 7'h44, 7'h7f};
        wr_reg(1'b0, 8'h27, 8'h01);
        for (int i = 0; i < 10; i++)
        begin
            wr_reg(1'b0, 8'h28, {1'b0, codes[i]});
            compare({2'h0, ext_den}, {2'h0, exp_den(codes[i])}, "divider");
            compare({9'h0, ext_en}, {9'h0, codes[i] != 7'h00}, "ext enable");
        end
        ext_scaled = 8'h05;
        wr_reg(1'b0, 8'h28, 8'hc0);
        compare({3'h0, ext_code}, 10'h005, "ext scaled code");
        compare({2'h0, ext_den}, 10'h032, "ext scaled divider");
        rd_check(1'b0, 8'h28, 8'hc0);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(1'b0, 8'h27, {6'h00, s[1:0]});
            compare({9'h0, ext_en}, {9'h0, s[0]}, "state decode");
        end
        $display("test ext decode done");
    endtask : test_ext_decode

    task automatic test_turnoff;
        nv_state_default = 2'h1;
        wr_reg(1'b0, 8'h26, 8'h20);
        wr_reg(1'b0, 8'h28, 8'h33);
        wr_reg(1'b0, 8'h27, 8'h02);
        turnoff_event = 1'b1;
        tick();
        turnoff_event = 1'b0;
        rd_check(1'b0, 8'h26, 8'h00);
        rd_check(1'b0, 8'h27, 8'h01);
        rd_check(1'b0, 8'h28, 8'h00);
        compare({9'h0, ext_en}, 10'h000, "enable after turnoff");
        fork
            wr_reg(1'b0, 8'h28, 8'h44);
            begin
                turnoff_event = 1'b1;
                tick();
                turnoff_event = 1'b0;
            end
        join
        rd_check(1'b0, 8'h28, 8'h00);
        $display("test turnoff done");
    endtask : test_turnoff

    initial
    begin
        rst_n = 1'b0;
        turnoff_event = 1'b0;
        port_select_bit = 1'b0;
        nv_state_default = 2'h2;
        gain = 2'h0;
        op_code = 8'h00;
        ext_scaled = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick();
        tick();
        test_reset_values();
        test_port_select();
        test_rail_decode();
        test_ext_decode();
        test_turnoff();
        complete_run();
    end
endmodule : tb_rail_voltage_select_regs
